// File: hdl/adcc_map.svh
/*
  Constants for the converter capture block: pin counts, lane spans,
  word layout and the top sample rates of each layout.
  Assumes it is included by bare name from hdl/.
*/
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Pin counts at the converter connector
`define ADCC_NLANE      35
`define ADCC_NGPIO      8

// Sample word and output slot layout
`define ADCC_RES_DEF    16
`define ADCC_WORD_W     16
`define ADCC_NSLOT      8

// Lanes captured per bus, and the frame lane's bit in the capture vector
`define ADCC_PAR_SPAN   16
`define ADCC_SER_LANES  8
`define ADCC_FRAME_BIT  16
`define ADCC_CAP_W      17

// Top sample rates per layout, in MHz
`define ADCC_BITWISE_MAX_MHZ  250
`define ADCC_SAMPLE_MAX_MHZ   1000
`define ADCC_SER1_MAX_MHZ     65
`define ADCC_SER2_MAX_MHZ     125

// Reset value of the general purpose lines
`define ADCC_GPIO_RST   8'h00

`endif

// File: hdl/adcc_pkg.sv
/*
  Types shared by the converter capture block.
  Assumes nothing of its surroundings.
*/
package adcc_pkg;

  // Lane layouts of the converter output
  typedef enum logic [1:0]
  {
    adcc_lay_bitwise    = 2'b00,
    adcc_lay_samplewise = 2'b01,
    adcc_lay_ser1       = 2'b10,
    adcc_lay_ser2       = 2'b11
  } adcc_layout_t;

  // One right-justified sample
  typedef logic [15:0] adcc_word_t;

endpackage : adcc_pkg

// File: hdl/adcc_word_if.sv
/*
  Carrier of assembled words from the link clock side to the crossing.
  Assumes data is held stable from each toggle of tgl to the next.
*/
`timescale 1ns/10ps

interface adcc_word_if
#(
  parameter int unsigned W = 128
);
  logic [W-1:0] data;
  logic         tgl;

  modport src (output data, output tgl);
  modport dst (input data, input tgl);
endinterface : adcc_word_if

// File: hdl/adcc_cdc.sv
/*
  Toggle crossing of one assembled word group into the system clock.
  Assumes the source toggles no more often than once per four system
  cycles and holds data stable between toggles.
*/
`timescale 1ns/10ps

module adcc_cdc
#(
  parameter int unsigned W = 128
)
(
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         ce,
  adcc_word_if.dst          link,
  output logic [W-1:0]      word,
  output logic              valid
);

  logic [2:0]   tgl_sync;
  logic [2:0]   next_tgl_sync;
  logic [W-1:0] word_q;
  logic [W-1:0] next_word;
  logic         valid_q;
  logic         next_valid;

  // Sync the toggle, take data on a seen change
  always_comb
  begin
    next_tgl_sync = tgl_sync;
    next_word     = word_q;
    next_valid    = 1'h0;
    if (ce)
    begin
      next_tgl_sync = {tgl_sync[1:0], link.tgl};
      if (tgl_sync[2] != tgl_sync[1])
      begin
        next_word  = link.data;  // Held stable by the source
        next_valid = 1'h1;
      end
    end
  end

  // Register crossing state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tgl_sync <= 3'h0;
      word_q   <= '0;
      valid_q  <= 1'h0;
    end
    else
    begin
      tgl_sync <= next_tgl_sync;
      word_q   <= next_word;
      valid_q  <= next_valid;
    end
  end

  assign word  = word_q;
  assign valid = valid_q;

endmodule : adcc_cdc

// File: hdl/adcc_capture.sv
/*
  Capture of converter samples from source-synchronous lanes: bit-wise
  and sample-wise double data rate, one-wire and two-wire serial.
  Assumes the converter drives all lanes and both clocks, and that the
  link clock runs at least four times slower than the system clock.
*/
`timescale 1ns/10ps
`include "adcc_map.svh"

module adcc_capture
#(
  parameter adcc_pkg::adcc_layout_t LAYOUT   = adcc_pkg::adcc_lay_bitwise,
  parameter int unsigned            RES      = `ADCC_RES_DEF,
  parameter bit                     DUAL_BUS = 1'h0
)
(
  input  wire logic                                      clock,
  input  wire logic                                      srst,
  input  wire logic                                      ce,
  input  wire logic                                      lane_bit_clk,
  input  wire logic                                      frame_boundary_clock,
  input  wire logic [`ADCC_NLANE-1:0]                    lane_in,
  input  wire logic [`ADCC_NGPIO-1:0]                    gpio_ctl,
  output logic      [`ADCC_NGPIO-1:0]                    gpio_out,
  output logic      [`ADCC_NSLOT-1:0][`ADCC_WORD_W-1:0]  sample_word,
  output logic      [`ADCC_NSLOT-1:0]                    sample_valid
);

  localparam bit SERIAL = (LAYOUT == adcc_pkg::adcc_lay_ser1) || (LAYOUT == adcc_pkg::adcc_lay_ser2);
  localparam bit SER2   = (LAYOUT == adcc_pkg::adcc_lay_ser2);
  localparam bit BITW   = (LAYOUT == adcc_pkg::adcc_lay_bitwise);
  // half as many lanes as bits; one lane per bit
  localparam int unsigned NLP    = BITW ? RES / 2 : RES;
  // bits per lane per frame; halved on two wires
  localparam int unsigned LW     = SER2 ? RES / 2 : RES;
  // channel count on eight serial lanes
  localparam int unsigned NCH    = SER2 ? `ADCC_SER_LANES / 2 : `ADCC_SER_LANES;
  // second bus only in a parallel layout
  localparam int unsigned NBUS   = (DUAL_BUS && !SERIAL) ? 2 : 1;
  localparam int unsigned SPB    = SERIAL ? NCH : (BITW ? 1 : 2);
  localparam int unsigned SLOTW  = `ADCC_NSLOT * `ADCC_WORD_W;
  localparam logic [15:0] RES_MASK = 16'((32'h1 << RES) - 32'h1);
  localparam logic [15:0] LW_MASK  = 16'((32'h1 << LW) - 32'h1);

  logic [SLOTW-1:0]                         bus_word [NBUS];
  logic [NBUS-1:0]                          bus_valid;
  logic [`ADCC_NGPIO-1:0]                   gpio_q;
  logic [`ADCC_NGPIO-1:0]                   next_gpio;
  logic [`ADCC_NSLOT-1:0][`ADCC_WORD_W-1:0] words_q;
  logic [`ADCC_NSLOT-1:0][`ADCC_WORD_W-1:0] next_words;
  logic [`ADCC_NSLOT-1:0]                   valid_q;
  logic [`ADCC_NSLOT-1:0]                   next_valid;

  // Interleave rising-edge odd bits with falling-edge even bits
  function automatic adcc_pkg::adcc_word_t f_merge(input logic [15:0] odd_half, input logic [15:0] even_half);
    adcc_pkg::adcc_word_t w;
    w = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      w[2 * i + 1] = odd_half[i];
      w[2 * i]     = even_half[i];
    end
    return w & RES_MASK;
  endfunction : f_merge

  // Word that closed on a frame edge, aligned on rise or fall
  function automatic adcc_pkg::adcc_word_t f_lane_word(input logic [15:0] hist, input logic rbit,
                                                        input logic at_fall);
    adcc_pkg::adcc_word_t w;
    w = at_fall ? {hist[14:0], rbit} : hist;
    return w & LW_MASK;
  endfunction : f_lane_word

  // general purpose lines toward the converter board
  always_comb
  begin
    next_gpio = ce ? gpio_ctl : gpio_q;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      gpio_q <= `ADCC_GPIO_RST;
    else
      gpio_q <= next_gpio;
  end

  assign gpio_out = gpio_q;

  genvar b;
  generate
    for (b = 0; b < NBUS; b = b + 1)
    begin : g_bus
      wire logic                 lclk;
      logic [1:0]                rst_sync;
      logic [1:0]                ce_sync;
      logic                      lrst;
      logic                      lce;
      logic [`ADCC_CAP_W-1:0]    cap_pins;
      logic [`ADCC_CAP_W-1:0]    rise_q;
      logic [`ADCC_CAP_W-1:0]    next_rise;
      logic [`ADCC_CAP_W-1:0]    fall_q;
      logic [`ADCC_CAP_W-1:0]    next_fall;
      logic [15:0]               sr [`ADCC_SER_LANES];
      logic [15:0]               next_sr [`ADCC_SER_LANES];
      adcc_pkg::adcc_word_t      lw [`ADCC_SER_LANES];
      logic                      b_rise;
      logic                      b_fall;
      logic                      fr_last;
      logic                      next_fr_last;
      logic [SLOTW-1:0]          word_q;
      logic [SLOTW-1:0]          next_word;
      logic                      tgl_q;
      logic                      next_tgl;

      adcc_word_if #(.W(SLOTW)) xfer ();

      if (b == 0)
      begin : g_bitclk
        // one bit clock for every lane of the first bus
        assign lclk = lane_bit_clk;
      end
      else
      begin : g_frmclk
        // frame lane clocks the second bus
        assign lclk = frame_boundary_clock;
      end

      // lanes are inputs only, never driven
      assign cap_pins = {(SERIAL ? frame_boundary_clock : 1'h0), lane_in[b * NLP +: `ADCC_PAR_SPAN]};

      // Bring reset and enable into the link clock
      always_ff @(posedge lclk)
      begin
        rst_sync <= {rst_sync[0], srst};
        ce_sync  <= {ce_sync[0], ce};
      end

      assign lrst = rst_sync[1];
      assign lce  = ce_sync[1];

      always_comb
      begin
        next_rise = lce ? cap_pins : rise_q;
      end

      always_ff @(posedge lclk)
      begin
        rise_q <= next_rise;
      end

      always_comb
      begin
        next_fall = lce ? cap_pins : fall_q;
      end

      always_ff @(negedge lclk)
      begin
        fall_q <= next_fall;
      end

      // Assemble one word group per link cycle or frame
      always_comb
      begin
        next_word    = word_q;
        next_tgl     = tgl_q;
        next_fr_last = fr_last;
        b_rise       = 1'h0;
        b_fall       = 1'h0;
        for (int l = 0; l < `ADCC_SER_LANES; l++)
        begin
          next_sr[l] = sr[l];
          lw[l]      = 16'h0000;
        end
        if (lce)
        begin
          case (LAYOUT)
            adcc_pkg::adcc_lay_bitwise:
            begin
              // odd bits on rise, even bits on fall
              next_word = {{(SLOTW - 16){1'h0}}, f_merge(rise_q[15:0], fall_q[15:0])};
              next_tgl  = ~tgl_q;
            end
            adcc_pkg::adcc_lay_samplewise:
            begin
              // rising sample in slot 0, falling in slot 1
              next_word = {{(SLOTW - 32){1'h0}}, fall_q[15:0] & RES_MASK, rise_q[15:0] & RES_MASK};
              next_tgl  = ~tgl_q;
            end
            default:
            begin
              // frame level going high opens a word
              b_rise       = !fr_last && rise_q[`ADCC_FRAME_BIT];
              b_fall       = !rise_q[`ADCC_FRAME_BIT] && fall_q[`ADCC_FRAME_BIT];
              next_fr_last = fall_q[`ADCC_FRAME_BIT];
              for (int l = 0; l < `ADCC_SER_LANES; l++)
              begin
                // two bits per bit clock, oldest first
                next_sr[l] = {sr[l][13:0], rise_q[l], fall_q[l]};
                lw[l]      = f_lane_word(sr[l], rise_q[l], b_fall);
              end
              for (int c = 0; c < NCH; c++)
              begin
                if (SER2)
                  // upper half on even lane, lower on odd
                  next_word[c * 16 +: 16] = 16'(lw[(2 * c) % 8] << LW) | lw[(2 * c + 1) % 8];
                else
                  next_word[c * 16 +: 16] = lw[c];
              end
              if (b_rise || b_fall)
                next_tgl = ~tgl_q;
            end
          endcase
        end
      end

      // Register assembly state
      always_ff @(posedge lclk)
      begin
        if (lrst)
        begin
          tgl_q   <= 1'h0;
          fr_last <= 1'h1;  // No boundary before a real frame edge
          word_q  <= '0;
        end
        else
        begin
          tgl_q   <= next_tgl;
          fr_last <= next_fr_last;
          word_q  <= next_word;
        end
        for (int l = 0; l < `ADCC_SER_LANES; l++)
          sr[l] <= next_sr[l];
      end

      assign xfer.data = word_q;
      assign xfer.tgl  = tgl_q;

      // Hand each word group to the system clock
      adcc_cdc #(.W(SLOTW)) u_cdc
      (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .link  (xfer),
        .word  (bus_word[b]),
        .valid (bus_valid[b])
      );
    end
  endgenerate

  // place each bus in its own output slots
  always_comb
  begin
    next_words = words_q;
    next_valid = '0;
    if (ce)
    begin
      for (int k = 0; k < NBUS; k++)
      begin
        if (bus_valid[k])
        begin
          next_words[k * SPB +: SPB] = bus_word[k][SPB * 16 - 1:0];
          next_valid[k * SPB +: SPB] = {SPB{1'h1}};
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      words_q <= '0;
      valid_q <= '0;
    end
    else
    begin
      words_q <= next_words;
      valid_q <= next_valid;
    end
  end

  assign sample_word  = words_q;
  assign sample_valid = valid_q;

endmodule : adcc_capture

// File: sim/adcc_capture_monitor.sv
/*
  Port checker of the capture block, bound in from the bench.
  Assumes one system clock and a link clock eight system periods long.
*/
`timescale 1ns/10ps
`include "adcc_map.svh"

module adcc_capture_monitor
#(
  parameter adcc_pkg::adcc_layout_t LAYOUT   = adcc_pkg::adcc_lay_bitwise,
  parameter int unsigned            RES      = `ADCC_RES_DEF,
  parameter bit                     DUAL_BUS = 1'h0
)
(
  input wire logic                                     clock,
  input wire logic                                     srst,
  input wire logic                                     ce,
  input wire logic                                     lane_bit_clk,
  input wire logic                                     frame_boundary_clock,
  input wire logic [`ADCC_NLANE-1:0]                   lane_in,
  input wire logic [`ADCC_NGPIO-1:0]                   gpio_ctl,
  input wire logic [`ADCC_NGPIO-1:0]                   gpio_out,
  input wire logic [`ADCC_NSLOT-1:0][`ADCC_WORD_W-1:0] sample_word,
  input wire logic [`ADCC_NSLOT-1:0]                   sample_valid
);
  int unsigned gap;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Cycles since the last slot 0 word while enabled
  always_ff @(posedge clock)
  begin
    if (srst || !ce || sample_valid[0])
      gap <= 0;
    else
      gap <= gap + 1;
  end

  property p_rst_clear;
    disable iff (1'h0) srst |=> gpio_out == 8'h00 && sample_word == '0 && sample_valid == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared in reset");
  property p_first_edge;
    $fell(srst) |-> sample_valid == 8'h00 && gpio_out == 8'h00;
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("outputs moved at reset release");
  property p_gpio_follow;
    ce |=> gpio_out == $past(gpio_ctl);
  endproperty
  a_gpio_follow: assert property (p_gpio_follow) else $error("gpio lines do not follow");
  property p_gpio_hold;
    !ce |=> $stable(gpio_out);
  endproperty
  a_gpio_hold: assert property (p_gpio_hold) else $error("gpio lines moved while disabled");
  property p_valid_gap;
    sample_valid[0] |=> !sample_valid[0] [*3];
  endproperty
  a_valid_gap: assert property (p_valid_gap) else $error("slot 0 words too close");
  property p_word_on_valid;
    $changed(sample_word[0]) |-> sample_valid[0];
  endproperty
  a_word_on_valid: assert property (p_word_on_valid) else $error("slot 0 word changed silently");
  property p_slots_unused;
    (LAYOUT == adcc_pkg::adcc_lay_bitwise && !DUAL_BUS) |-> sample_valid[7:1] == 7'h00;
  endproperty
  a_slots_unused: assert property (p_slots_unused) else $error("unused slot pulsed");
  property p_valid_live;
    gap < 60;
  endproperty
  a_valid_live: assert property (p_valid_live) else $error("no word from a running link");
endmodule : adcc_capture_monitor

// File: sim/adcc_conv_model.sv
/*
  Converter model, bit-wise double data rate, 16-bit samples.
  Assumes the bench queues samples through send; idle periods carry filler.
*/
`timescale 1ns/10ps

module adcc_conv_model
(
  output logic        lane_bit_clk,
  output logic        frame_boundary_clock,
  output logic [34:0] lane_in
);
  logic [15:0] q[$];
  logic [15:0] w;
  logic [7:0]  idle;

  // Queue a sample for a later link period
  task automatic send(input logic [15:0] s);
    q.push_back(s);
  endtask : send

  // Free running 80 ns link clock, data launched 20 ns before each edge
  initial
  begin
    lane_bit_clk = 1'h0;
    frame_boundary_clock = 1'h0;
    lane_in = '0;
    idle = 8'h00;
    #7;
    forever
    begin
      w = (q.size() != 0) ? q.pop_front() : {8'hEE, idle};
      idle = idle + 8'h01;
      lane_in[34:8] = ~lane_in[34:8];
      frame_boundary_clock = ~frame_boundary_clock;
      for (int i = 0; i < 8; i++) lane_in[i] = w[2*i+1];
      #20 lane_bit_clk = 1'h1;
      #20 lane_in[34:8] = ~lane_in[34:8];
      for (int i = 0; i < 8; i++) lane_in[i] = w[2*i];
      #20 lane_bit_clk = 1'h0;
      #20;
    end
  end
endmodule : adcc_conv_model

// File: sim/test_adcc_capture.sv
/*
  Bench of the capture block in the bit-wise layout.
  Assumes the converter model drives all lanes and the link clock.
*/
`timescale 1ns/10ps

module test_adcc_capture;
  logic                  clock;
  logic                  srst;
  logic                  ce;
  logic                  lane_bit_clk;
  logic                  frame_boundary_clock;
  logic [34:0]           lane_in;
  logic [7:0]            gpio_ctl;
  logic [7:0]            gpio_out;
  logic [7:0][15:0]      sample_word;
  logic [7:0]            sample_valid;
  int                    num_errors;
  int                    num_checks;
  bit                    hung;
  adcc_pkg::adcc_word_t  got[$];

  adcc_capture #(.LAYOUT(adcc_pkg::adcc_lay_bitwise), .RES(16), .DUAL_BUS(1'h0)) i_adcc_capture
  (
    .clock(clock), .srst(srst), .ce(ce), .lane_bit_clk(lane_bit_clk),
    .frame_boundary_clock(frame_boundary_clock), .lane_in(lane_in), .gpio_ctl(gpio_ctl),
    .gpio_out(gpio_out), .sample_word(sample_word), .sample_valid(sample_valid)
  );

  adcc_conv_model i_adcc_conv_model
  (
    .lane_bit_clk(lane_bit_clk), .frame_boundary_clock(frame_boundary_clock), .lane_in(lane_in)
  );

  // System clock, 10 ns
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Keep every slot 0 word that is not idle filler
  always @(negedge clock)
    if (sample_valid[0] === 1'h1 && sample_word[0][15:8] !== 8'hEE)
      got.push_back(sample_word[0]);

  task automatic check_val(input logic [15:0] act, input logic [15:0] exp, input string what);
    num_checks++;
    if (act !== exp)
    begin
      $display("wrong value at %0t: %s got %h want %h", $time, what, act, exp);
      num_errors++;
    end
  endtask : check_val

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Reset held for the given cycles, outputs cleared; mid-run needs 30 so the link side clears first
  task automatic test_reset(input int cycles);
    srst = 1'h1;
    repeat (cycles) @(negedge clock);
    check_val({8'h00, gpio_out}, 16'h0000, "gpio in reset");
    check_val(sample_word[0], 16'h0000, "word in reset");
    check_val({8'h00, sample_valid}, 16'h0000, "valid in reset");
    srst = 1'h0;
    $display("test reset done");
  endtask : test_reset

  // General purpose lines follow, and hold while disabled
  task automatic test_gpio();
    logic [7:0] v [5] = '{8'hA5, 8'h5A, 8'hFF, 8'h00, 8'h81};
    foreach (v[k])
    begin
      gpio_ctl = v[k];
      @(negedge clock);
      check_val({8'h00, gpio_out}, {8'h00, v[k]}, "gpio follow");
    end
    ce = 1'h0;
    gpio_ctl = 8'h3C;
    repeat (3) @(negedge clock);
    check_val({8'h00, gpio_out}, 16'h0081, "gpio hold");
    ce = 1'h1;
    @(negedge clock);
    check_val({8'h00, gpio_out}, 16'h003C, "gpio resume");
    $display("test gpio done");
  endtask : test_gpio

  // Back-to-back samples with edge and alternating bit patterns
  task automatic test_bitwise();
    logic [15:0] w [6] = '{16'h8001, 16'h7FFE, 16'hFFFF, 16'h0000, 16'h5AA5, 16'hC3A5};
    int n;
    repeat (40) @(negedge clock);
    got.delete();
    foreach (w[k]) i_adcc_conv_model.send(w[k]);
    n = 0;
    while (got.size() < 6 && n < 400)
    begin
      @(negedge clock);
      n++;
    end
    if (got.size() < 6)
    begin
      $display("wrong value at %0t: samples missing", $time);
      num_errors++;
      hung = 1'h1;
    end
    else
    begin
      foreach (w[k]) check_val(got[k], w[k], "sample");
    end
    $display("test bitwise done");
  endtask : test_bitwise

  // Main sequence, with a second reset in mid-run
  initial
  begin
    srst = 1'h1;
    ce = 1'h1;
    gpio_ctl = 8'h00;
    num_errors = 0;
    num_checks = 0;
    hung = 1'h0;
    test_reset(20);
    test_gpio();
    test_bitwise();
    // A timed-out scenario goes straight to the report
    if (!hung)
    begin
      test_reset(30);
      test_bitwise();
    end
    conclude();
  end
endmodule : test_adcc_capture

bind adcc_capture adcc_capture_monitor #(.LAYOUT(LAYOUT), .RES(RES), .DUAL_BUS(DUAL_BUS)) i_adcc_capture_monitor
(
  .clock(clock), .srst(srst), .ce(ce), .lane_bit_clk(lane_bit_clk),
  .frame_boundary_clock(frame_boundary_clock), .lane_in(lane_in), .gpio_ctl(gpio_ctl),
  .gpio_out(gpio_out), .sample_word(sample_word), .sample_valid(sample_valid)
);
